// >>> hw/sim_pkg.sv
package sim_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] SIM_CSR_OFFSET     = 4'h0;
    localparam logic [7:0] SIM_CSR_RESET      = 8'h00;
    localparam int         SIM_BIT_SRC_SEL    = 7;
    localparam int         SIM_BIT_IRQ_EN     = 6;
    localparam int         SIM_BIT_CMP_FLAG   = 5;
    localparam int         SIM_BIT_LVD_CAUSE  = 4;
    localparam int         SIM_BIT_WDG_CAUSE  = 0;
    // ************************************************************
    // Reset delay
    // ************************************************************
    localparam int         SIM_DELAY_SHORT    = 256;
    localparam int         SIM_DELAY_LONG     = 4096;
    localparam int         SIM_CNT_W          = 13;
    // ************************************************************
    // Threshold levels
    // ************************************************************
    localparam logic [1:0] SIM_LVL_LOW        = 2'h0;
    localparam logic [1:0] SIM_LVL_MED        = 2'h1;
    localparam logic [1:0] SIM_LVL_HIGH       = 2'h2;
endpackage : sim_pkg

// >>> hw/sim_supply_monitor.sv
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module sim_supply_monitor
    import sim_pkg::*;
(
    // Clock and reset
    input  wire logic                 SYS_CLK,
    input  wire logic                 RST,
    // Static options
    input  wire logic                 LOW_SUPPLY_DETECTOR_EN,
    input  wire logic [1:0]           THRESHOLD_LEVEL,
    input  wire logic                 LONG_RESET_DELAY,
    // Comparator inputs
    input  wire logic                 LOW_SUPPLY_BELOW,
    input  wire logic                 MAIN_SUPPLY_BELOW,
    input  wire logic                 EXTERNAL_SENSE_BELOW,
    // Reset sources and reset pin
    input  wire logic                 WATCHDOG_RESET,
    input  wire logic                 RESET_PIN_IN,
    output logic                      RESET_PIN_OUT,
    output logic                      RESET_PIN_OE,
    output logic                      CORE_RESET,
    // CPU side
    input  wire logic                 CPU_GLOBAL_MASK,
    input  wire logic                 IRQ_SERVICE_ENTRY,
    input  wire logic                 HALT_MODE,
    input  wire logic                 WAIT_MODE,
    output logic                      IRQ_REQUEST,
    output logic                      WAKE_FROM_WAIT,
    output logic [1:0]                THRESHOLD_SELECT,
    // Register port
    input  wire logic [3:0]           REG_ADDR,
    input  wire logic [7:0]           REG_WDATA,
    input  wire logic                 REG_WR,
    input  wire logic                 REG_RD,
    output logic      [7:0]           REG_RDATA
);
    import sim_pkg::*;

    // ************************************************************
    // Reset sequencing
    // ************************************************************
    typedef enum logic [2:0] {
        SIM_RUN   = 3'b001,
        SIM_HOLD  = 3'b010,
        SIM_DELAY = 3'b100
    } sim_state_e;

    sim_state_e                 state_q;
    logic [SIM_CNT_W-1:0]       delay_q;
    logic                       lvd_active;
    logic                       any_reset;
    logic [SIM_CNT_W-1:0]       delay_len;

    assign lvd_active = LOW_SUPPLY_DETECTOR_EN & LOW_SUPPLY_BELOW;
    // The pin is only heard while we release it; otherwise our own pull would lock us in reset.
    assign any_reset  = lvd_active | WATCHDOG_RESET | (~RESET_PIN_IN & (state_q == SIM_RUN));
    assign delay_len  = LONG_RESET_DELAY ? SIM_CNT_W'(SIM_DELAY_LONG - 1)
                                         : SIM_CNT_W'(SIM_DELAY_SHORT - 1);

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_q <= SIM_HOLD;
            delay_q <= '0;
        end else begin
            case (state_q)
                SIM_RUN: begin
                    if (any_reset) begin
                        state_q <= SIM_HOLD;
                    end
                end
                SIM_HOLD: begin
                    // Comparator hysteresis lives in the analog part; we follow its level.
                    if (!any_reset) begin
                        state_q <= SIM_DELAY;
                        delay_q <= delay_len;
                    end
                end
                SIM_DELAY: begin
                    if (any_reset) begin
                        state_q <= SIM_HOLD;
                    end else if (delay_q == '0) begin
                        state_q <= SIM_RUN;
                    end else begin
                        delay_q <= delay_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= SIM_HOLD;
                end
            endcase
        end
    end

    assign CORE_RESET       = (state_q != SIM_RUN);
    // The pin is held low for the whole delay too, so the board sees one clean pulse.
    assign RESET_PIN_OUT    = 1'b0;
    assign RESET_PIN_OE     = lvd_active | (state_q != SIM_RUN);
    assign THRESHOLD_SELECT = THRESHOLD_LEVEL;

    // ************************************************************
    // Auxiliary comparator
    // ************************************************************
    logic src_sel_q;
    logic irq_en_q;
    logic flag_q;
    logic lvd_cause_q;
    logic wdg_cause_q;
    logic pend_q;
    logic flag_d;
    logic wr_csr;

    assign wr_csr = REG_WR && (REG_ADDR == SIM_CSR_OFFSET) && !HALT_MODE;
    assign flag_d = src_sel_q ? EXTERNAL_SENSE_BELOW : MAIN_SUPPLY_BELOW;

    // The flag also follows its source while the core is held in reset, so a fast power-up that
    // crosses the threshold inside the reset delay leaves no edge behind.
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            flag_q <= 1'b0;
        end else if (!LOW_SUPPLY_DETECTOR_EN) begin
            flag_q <= 1'b0;
        end else if (CORE_RESET) begin
            flag_q <= flag_d;
        end else if (!HALT_MODE) begin
            flag_q <= flag_d;
        end
    end

    // ************************************************************
    // Control bits and reset causes
    // ************************************************************
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            src_sel_q <= SIM_CSR_RESET[SIM_BIT_SRC_SEL];
            irq_en_q  <= SIM_CSR_RESET[SIM_BIT_IRQ_EN];
        end else if (CORE_RESET) begin
            src_sel_q <= SIM_CSR_RESET[SIM_BIT_SRC_SEL];
            irq_en_q  <= SIM_CSR_RESET[SIM_BIT_IRQ_EN];
        end else if (wr_csr) begin
            src_sel_q <= REG_WDATA[SIM_BIT_SRC_SEL];
            irq_en_q  <= REG_WDATA[SIM_BIT_IRQ_EN];
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            lvd_cause_q <= SIM_CSR_RESET[SIM_BIT_LVD_CAUSE];
            wdg_cause_q <= SIM_CSR_RESET[SIM_BIT_WDG_CAUSE];
        end else if (lvd_active) begin
            lvd_cause_q <= 1'b1;
            wdg_cause_q <= 1'b0;
        end else if (WATCHDOG_RESET) begin
            wdg_cause_q <= 1'b1;
        end else if (wr_csr) begin
            // Software clears bits only by a zero write; a one leaves them alone.
            if (!REG_WDATA[SIM_BIT_LVD_CAUSE]) begin
                lvd_cause_q <= 1'b0;
            end
            if (!REG_WDATA[SIM_BIT_WDG_CAUSE]) begin
                wdg_cause_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Interrupt request
    // ************************************************************
    logic irq_en_rise;
    logic flag_change;

    // Setting the enable counts as an event so a slow rise yields two requests.
    assign irq_en_rise = wr_csr && REG_WDATA[SIM_BIT_IRQ_EN] && !irq_en_q;
    assign flag_change = !CORE_RESET && !HALT_MODE && (flag_d != flag_q)
                         && LOW_SUPPLY_DETECTOR_EN;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pend_q <= 1'b0;
        end else if (CORE_RESET || !LOW_SUPPLY_DETECTOR_EN) begin
            pend_q <= 1'b0;
        end else if ((flag_change && irq_en_q) || irq_en_rise) begin
            pend_q <= 1'b1;
        end else if (IRQ_SERVICE_ENTRY || (wr_csr && !REG_WDATA[SIM_BIT_IRQ_EN])) begin
            pend_q <= 1'b0;
        end
    end

    assign IRQ_REQUEST    = pend_q && irq_en_q && !CPU_GLOBAL_MASK;
    assign WAKE_FROM_WAIT = pend_q && irq_en_q && WAIT_MODE && !HALT_MODE;

    // ************************************************************
    // Read port
    // ************************************************************
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD && (REG_ADDR == SIM_CSR_OFFSET)) begin
            REG_RDATA <= {src_sel_q, irq_en_q, flag_q, lvd_cause_q,
                          3'h0, wdg_cause_q};
        end else begin
            REG_RDATA <= 8'h00;
        end
    end

endmodule : sim_supply_monitor

// >>> dv/sim_supply_monitor_asserts.sv
`timescale 1ns/1ps
module sim_supply_monitor_asserts (
    // Clock, reset and options
    input wire logic       SYS_CLK,
    input wire logic       RST,
    input wire logic       LOW_SUPPLY_DETECTOR_EN,
    input wire logic       LOW_SUPPLY_BELOW,
    // Reset pin, core and CPU side
    input wire logic       RESET_PIN_OUT,
    input wire logic       RESET_PIN_OE,
    input wire logic       CORE_RESET,
    input wire logic       CPU_GLOBAL_MASK,
    input wire logic       IRQ_SERVICE_ENTRY,
    input wire logic       HALT_MODE,
    input wire logic       WAIT_MODE,
    input wire logic       IRQ_REQUEST,
    input wire logic       WAKE_FROM_WAIT,
    // Register port
    input wire logic [3:0] REG_ADDR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_RDATA
);
    // ****
    // Checks
    // ****
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    a_lvd_holds_core: assert property ((LOW_SUPPLY_DETECTOR_EN && LOW_SUPPLY_BELOW)[*3]
        |-> CORE_RESET && RESET_PIN_OE) else $error("core free in low supply");
    a_pin_open_drain: assert property (RESET_PIN_OUT == 1'b0)
        else $error("reset pin driven high");
    a_irq_masked: assert property (CPU_GLOBAL_MASK |-> !IRQ_REQUEST)
        else $error("irq through mask");
    a_aux_disabled: assert property (!LOW_SUPPLY_DETECTOR_EN |-> !IRQ_REQUEST)
        else $error("irq with detector off");
    a_service_clears: assert property (IRQ_SERVICE_ENTRY && !HALT_MODE |=> !IRQ_REQUEST)
        else $error("irq kept after service");
    a_wake_in_wait: assert property (WAKE_FROM_WAIT |-> WAIT_MODE && !HALT_MODE)
        else $error("wake outside wait");
    a_wake_follows_irq: assert property (IRQ_REQUEST && WAIT_MODE && !HALT_MODE |-> WAKE_FROM_WAIT)
        else $error("no wake");
    // Halt stops new pending events, but service entry still clears the bit; the check expects the request to move only with the mask.
    a_halt_frozen: assert property (HALT_MODE ##1 (HALT_MODE && $stable(CPU_GLOBAL_MASK))
        |-> $stable(IRQ_REQUEST)) else $error("irq moved in halt");
    a_reserved_zero: assert property (REG_RD |=> REG_RDATA[3:1] == 3'h0)
        else $error("reserved bits set");
    a_unmapped_zero: assert property (REG_RD && REG_ADDR != 4'h0 |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    cover property ($rose(IRQ_REQUEST));
    cover property ($fell(CORE_RESET));
    cover property (WAKE_FROM_WAIT);
endmodule : sim_supply_monitor_asserts
bind sim_supply_monitor sim_supply_monitor_asserts sim_supply_monitor_asserts_i (.*);

// >>> dv/sim_supply_monitor_tb.sv
`timescale 1ns/1ps
module sim_supply_monitor_tb;
    import sim_pkg::*;
    // ****
    // Harness
    // ****
    logic SYS_CLK, RST, LOW_SUPPLY_DETECTOR_EN, LONG_RESET_DELAY, LOW_SUPPLY_BELOW, ext_low;
    logic MAIN_SUPPLY_BELOW, EXTERNAL_SENSE_BELOW, WATCHDOG_RESET, RESET_PIN_IN, RESET_PIN_OUT;
    logic RESET_PIN_OE, CORE_RESET, CPU_GLOBAL_MASK, IRQ_SERVICE_ENTRY, HALT_MODE, WAIT_MODE;
    logic IRQ_REQUEST, WAKE_FROM_WAIT, REG_WR, REG_RD;
    logic [1:0] THRESHOLD_LEVEL, THRESHOLD_SELECT;
    logic [3:0] REG_ADDR;
    logic [7:0] REG_WDATA, REG_RDATA, rd;
    int fails, samples_checked, seed, n, dly;
    // The pin has a pull-up, so it reads low whenever either side pulls it.
    assign RESET_PIN_IN = !(RESET_PIN_OE || ext_low);
    sim_supply_monitor sim_supply_monitor_i (.*);
    initial begin
        SYS_CLK = 1'b0;
        forever #4 SYS_CLK = ~SYS_CLK;
    end
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m = 8'hff);
        samples_checked++;
        if ((got & m) !== (exp & m)) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic tick(input int k);
        repeat (k) @(posedge SYS_CLK);
    endtask : tick
    task automatic wr(input logic [7:0] d);
        @(posedge SYS_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= SIM_CSR_OFFSET;
        REG_WDATA <= d;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
    endtask : wr
    task automatic rd8(input logic [3:0] a);
        @(posedge SYS_CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        #1 rd = REG_RDATA;
    endtask : rd8
    task automatic svc();
        @(posedge SYS_CLK);
        IRQ_SERVICE_ENTRY <= 1'b1;
        @(posedge SYS_CLK);
        IRQ_SERVICE_ENTRY <= 1'b0;
        #1 cmp(8'(IRQ_REQUEST), 8'h00);
    endtask : svc
    // A bounded wait; the slack above the delay covers the cycle spent in hold before the count starts.
    task automatic wait_core(input int lo);
        n = 0;
        while (CORE_RESET !== 1'b0) begin
            @(posedge SYS_CLK);
            #1;
            n++;
            if (n > 5000) begin
                fails++;
                summarize();
            end
        end
        cmp(8'(n >= lo && n <= lo + 6), 8'h01);
    endtask : wait_core
    task automatic hrst(input logic en, input logic lng, input logic [1:0] lvl);
        @(posedge SYS_CLK);
        {RST, LOW_SUPPLY_DETECTOR_EN, LONG_RESET_DELAY, THRESHOLD_LEVEL} <= {1'b1, en, lng, lvl};
        dly = lng ? SIM_DELAY_LONG : SIM_DELAY_SHORT;
        tick(20);
        RST <= 1'b0;
        wait_core(dly);
        cmp(8'(THRESHOLD_SELECT), 8'(lvl));
    endtask : hrst
    task automatic srst(input logic [2:0] src, input logic [7:0] exp);
        @(posedge SYS_CLK);
        {WATCHDOG_RESET, LOW_SUPPLY_BELOW, ext_low} <= src;
        tick(6);
        cmp(8'(CORE_RESET), 8'h01);
        {WATCHDOG_RESET, LOW_SUPPLY_BELOW, ext_low} <= 3'h0;
        // An external pulse is heard only once, so its delay starts before the release.
        wait_core((src == 3'h1) ? dly - 6 : dly);
        rd8(SIM_CSR_OFFSET);
        cmp(rd, exp, 8'hdf);
    endtask : srst
    // ****
    // Scenarios
    // ****
    initial begin
        {seed, fails, samples_checked} = {32'd90, 64'd0};
        {REG_WR, REG_RD, REG_ADDR, REG_WDATA, WATCHDOG_RESET, LOW_SUPPLY_BELOW, ext_low} = '0;
        {MAIN_SUPPLY_BELOW, EXTERNAL_SENSE_BELOW, CPU_GLOBAL_MASK, IRQ_SERVICE_ENTRY} = 4'h0;
        {HALT_MODE, WAIT_MODE, RST, LOW_SUPPLY_DETECTOR_EN, LONG_RESET_DELAY} = 5'h0e;
        THRESHOLD_LEVEL = SIM_LVL_LOW;
        hrst(1'b1, 1'b0, SIM_LVL_LOW);
        rd8(SIM_CSR_OFFSET);
        cmp(rd, SIM_CSR_RESET);
        rd8(4'h9);
        cmp(rd, 8'h00);
        wr(8'hf1);
        rd8(SIM_CSR_OFFSET);
        cmp(rd, 8'hc0);
        cmp(8'(IRQ_REQUEST), 8'h01);
        svc();
        for (int i = 0; i < 30; i++) begin
            logic s, f0, f1;
            s = 1'($random(seed));
            wr({s, 7'h40});
            tick(3);
            svc();
            f0 = s ? EXTERNAL_SENSE_BELOW : MAIN_SUPPLY_BELOW;
            @(posedge SYS_CLK);
            {MAIN_SUPPLY_BELOW, EXTERNAL_SENSE_BELOW, CPU_GLOBAL_MASK, WAIT_MODE} <= 4'($random(seed));
            tick(4);
            f1 = s ? EXTERNAL_SENSE_BELOW : MAIN_SUPPLY_BELOW;
            cmp(8'(IRQ_REQUEST), 8'(f0 != f1 && !CPU_GLOBAL_MASK));
            cmp(8'(WAKE_FROM_WAIT), 8'(f0 != f1 && WAIT_MODE));
            rd8(SIM_CSR_OFFSET);
            cmp(rd, {s, 1'b1, f1, 5'h0}, 8'he0);
            svc();
        end
        $display("monitor events done");
        srst(3'h4, 8'h01);
        srst(3'h2, 8'h10);
        srst(3'h1, 8'h10);
        srst(3'h4, 8'h11);
        wr(8'h00);
        rd8(SIM_CSR_OFFSET);
        cmp(rd, 8'h00, 8'hdf);
        $display("reset causes done");
        wr(8'h40);
        svc();
        @(posedge SYS_CLK);
        {HALT_MODE, CPU_GLOBAL_MASK, WAIT_MODE} <= 3'h4;
        wr(8'h80);
        @(posedge SYS_CLK);
        {MAIN_SUPPLY_BELOW, EXTERNAL_SENSE_BELOW} <= ~{MAIN_SUPPLY_BELOW, EXTERNAL_SENSE_BELOW};
        tick(4);
        cmp(8'(IRQ_REQUEST), 8'h00);
        rd8(SIM_CSR_OFFSET);
        cmp(rd, 8'h40, 8'hdf);
        @(posedge SYS_CLK);
        HALT_MODE <= 1'b0;
        hrst(1'b0, 1'b1, SIM_LVL_HIGH);
        wr(8'h40);
        @(posedge SYS_CLK);
        MAIN_SUPPLY_BELOW <= ~MAIN_SUPPLY_BELOW;
        tick(4);
        cmp(8'(IRQ_REQUEST), 8'h00);
        rd8(SIM_CSR_OFFSET);
        cmp(rd, 8'h00, 8'h20);
        $display("halt and disabled done");
        summarize();
    end
endmodule : sim_supply_monitor_tb
